// ===== src/oc_params.svh
// constants and field layout for the overcurrent limit and response block
// Function
// - single phase fault and warning limits applied as 8 A to 62 A in 2 A steps
// - a limit between supported values is applied as the next higher value
// - limits written below 8 A are accepted but applied as 8 A
// - power cycle or store/restore replaces each limit by nearest storable value
// - stored limit copy holds up to 62 A in 0.25 A steps
// - all-phase fault limit write gives each phase written value divided by phases
// - all-phase fault limit read returns phase zero limit times phase count
// - single-phase fault limit write updates only that phase, unscaled
// - single-phase fault limit read returns that phase's own limit
// - overcurrent fault sets byte, word and current status bits, then alerts host
// - action 00/01 keeps running, 10 shuts down after delay, 11 shuts at once
// - restart count zero stays off after shutdown, no restart attempt
// - counts 1 to 6 wait a hiccup, restart up to that many times, then latch
// - count 7 waits a hiccup and retries without limit until off or success
// - delay codes 0-1: one switch period, hiccup one rise; 2-4: three, code rises
// - delay codes 5-7: seven switch periods, hiccup five to seven rise times
// - unsupported write to fault or warning limit rejected, status set, host alerted
// - warning limit is per phase; each phase reports its own warning
// - warning sets none-of-above, current word bit, warning bit, then alerts host
// - warning word linear: exponent 15:11 resets to 11110b, mantissa 10:0, amperes
// - warning limits up to 62 A times phase count are supported
// - each phase compares its own fault limit; stack limit is lowest times phases
`ifndef OC_PARAMS_SVH
`define OC_PARAMS_SVH
// ==========================================
// command codes and phase selection
`define CMD_FAULT_LIMIT 8'h46
`define CMD_FAULT_ACTION 8'h47
`define CMD_WARN_LIMIT 8'h4A
`define PHASE_ALL 8'hFF
`define PHASES 2
// ==========================================
// linear word layout
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define EXP_RST 5'b11110
`define EXP_MAX 5'sd4
`define EXP_FINE -5'sd6
`define FIX_FRAC 5'sd6
`define FIX_HALF_Q 24'sd8
`define FIX_Q_SHIFT 4
`define Q_MAX 24'sd248
`define FIX_LIMIT 24'sd3968
`define HW_STEP_RND 24'sd127
`define HW_STEP_SHIFT 7
`define HW_MIN_A 6'd8
`define HW_MAX_A 6'd62
`define HW_MAX_STEPS 24'sd31
`define HW_WARN_RST 6'd40
// ==========================================
// reset values of the stored settings
`define ACTION_RST 8'hC0
`define FAULT_W_RST 16'hF0F8
`define WARN_W_RST 16'hF0A0
// ==========================================
// status bit positions
`define SB_IOUT_OC 4
`define SB_CML 1
`define SB_NOTA 0
`define SW_IOUT 14
`define SI_OCF 7
`define SI_OCW 5
// ==========================================
// timing in switching periods, rise-time multiples
`define DLY_SHORT 3'd1
`define DLY_MID 3'd3
`define DLY_LONG 3'd7
`define RETRY_FOREVER 3'd7
`endif

// ===== src/oc_pkg.sv
// types of the overcurrent limit and response block
`include "oc_params.svh"
package oc_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DELAY = 3'b001,
    ST_HICCUP = 3'b010,
    ST_RESTART = 3'b011,
    ST_LATCH = 3'b100
  } oc_phase_st_t;
  typedef struct packed {
    logic [`PHASES-1:0][15:0] faultW;
    logic [`PHASES-1:0][15:0] warnW;
    logic [`PHASES-1:0][5:0] hwF;
    logic [`PHASES-1:0][5:0] hwW;
    logic [7:0] resp;
    logic [15:0] rdData;
    logic [7:0] stByte;
    logic [15:0] stWord;
    logic [7:0] stIout;
    oc_phase_st_t st;
    logic [2:0] dlyCnt;
    logic [2:0] hicCnt;
    logic [2:0] tries;
    logic ocPrev;
    logic [`PHASES-1:0] warnPrev;
    logic [`PHASES-1:0] warnSeen;
    logic [2*`PHASES-1:0] sync1;
    logic [2*`PHASES-1:0] sync2;
  } oc_state_t;
endpackage

// ===== src/overcurrent_limit_response.sv
// overcurrent limits, fault action and hiccup policy of the converter
`timescale 1ns/1ps
`include "oc_params.svh"
module overcurrent_limit_response
  import oc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdPhase,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  input wire logic nvmEvent,
  input wire logic clearStatus,
  input wire logic [`PHASES-1:0] ocFaultPin,
  input wire logic [`PHASES-1:0] ocWarnPin,
  input wire logic pwmTick,
  input wire logic riseTick,
  input wire logic opOn,
  input wire logic startupOk,
  output logic [`PHASES-1:0][5:0] hwFaultAmps,
  output logic [`PHASES-1:0][5:0] hwWarnAmps,
  output logic [7:0] statusByte,
  output logic [15:0] statusWord,
  output logic [7:0] statusIout,
  output logic [`PHASES-1:0] warnPhase,
  output logic alert,
  output logic convOn
);
  // ==========================================
  // linear format helpers
  // {bad, value in 1/64 A}; exponents above the range are refused, not wrapped
  function automatic logic [24:0] linFix(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [23:0] m;
    logic signed [23:0] f;
    logic bad;
    e = w[`EXP_MSB:`EXP_LSB];
    m = 24'(signed'(w[`MAN_MSB:0]));
    bad = 1'b0;
    f = '0;
    if (e > `EXP_MAX) begin
      bad = 1'b1;
    end else if (e >= `EXP_FINE) begin
      f = m <<< 4'(e + `FIX_FRAC);
    end else begin
      f = m >>> 4'(-(e + `FIX_FRAC));
    end
    return {bad, f};
  endfunction

  // per-phase word acceptable: not negative, not above the analog ceiling
  function automatic logic wordOk(input logic [15:0] w);
    logic [24:0] r;
    r = linFix(w);
    return !r[24] && !r[23] && (signed'(r[23:0]) <= `FIX_LIMIT);
  endfunction

  // ceiling to 2 A steps with an 8 A floor
  function automatic logic [5:0] hwAmps(input logic [15:0] w);
    logic [24:0] r;
    logic signed [23:0] s;
    logic [5:0] a;
    r = linFix(w);
    s = (signed'(r[23:0]) + `HW_STEP_RND) >>> `HW_STEP_SHIFT;
    a = {s[4:0], 1'b0};
    if (r[23] || s > `HW_MAX_STEPS) begin
      a = r[23] ? `HW_MIN_A : `HW_MAX_A;
    end
    if (a < `HW_MIN_A) begin
      a = `HW_MIN_A;
    end
    return a;
  endfunction

  // nearest quarter ampere, as the non-volatile copy holds it
  function automatic logic [15:0] nvmWord(input logic [15:0] w);
    logic [24:0] r;
    logic signed [23:0] q;
    r = linFix(w);
    q = (signed'(r[23:0]) + `FIX_HALF_Q) >>> `FIX_Q_SHIFT;
    if (q < 0) begin
      q = '0;
    end else if (q > `Q_MAX) begin
      q = `Q_MAX;
    end
    return {`EXP_RST, q[10:0]};
  endfunction

  function automatic logic [2:0] dlyTicks(input logic [2:0] c);
    return (c < 3'd2) ? `DLY_SHORT : (c < 3'd5) ? `DLY_MID : `DLY_LONG;
  endfunction

  function automatic logic [2:0] hicMult(input logic [2:0] c);
    return (c < 3'd2) ? 3'd1 : c;
  endfunction

  // ==========================================
  // state
  oc_state_t r;
  oc_state_t rNxt;
  logic faultNow;
  logic faultEdge;
  logic [`PHASES-1:0] warnNow;
  logic [`PHASES-1:0] warnEdge;
  logic allSel;
  logic phIdx;
  logic selOk;
  logic wrBad;
  logic [15:0] divW;

  assign faultNow = |r.sync2[`PHASES-1:0];
  assign faultEdge = faultNow && !r.ocPrev;
  assign warnNow = r.sync2[2*`PHASES-1:`PHASES];
  assign warnEdge = warnNow & ~r.warnPrev;
  assign allSel = cmdPhase == `PHASE_ALL;
  assign phIdx = cmdPhase[0];
  assign selOk = allSel || cmdPhase < 8'(`PHASES);
  // all-phase write: halving the word is one step down in exponent
  assign divW = {wrData[`EXP_MSB:`EXP_LSB] - 5'd1, wrData[`MAN_MSB:0]};

  always_comb begin
    rNxt = r;
    wrBad = 1'b0;
    rNxt.sync1 = {ocWarnPin, ocFaultPin};
    rNxt.sync2 = r.sync1;
    rNxt.ocPrev = faultNow;
    rNxt.warnPrev = warnNow;
    // host commands
    if (cmdValid && cmdWrite) begin
      unique case (cmdCode)
        `CMD_FAULT_LIMIT, `CMD_WARN_LIMIT: begin
          // a wrapped exponent on the halving would silently rescale, so refuse it
          wrBad = !selOk || (allSel ? (wrData[`EXP_MSB:`EXP_LSB] == 5'b10000
                  || !wordOk(divW)) : !wordOk(wrData));
          if (!wrBad) begin
            for (int i = 0; i < `PHASES; i++) begin
              if (allSel || phIdx == 1'(i)) begin
                if (cmdCode == `CMD_FAULT_LIMIT) begin
                  rNxt.faultW[i] = allSel ? divW : wrData;
                end else begin
                  rNxt.warnW[i] = allSel ? divW : wrData;
                end
              end
            end
          end
        end
        `CMD_FAULT_ACTION: begin
          rNxt.resp = wrData[7:0];
        end
        default: begin
        end
      endcase
    end else if (cmdValid) begin
      unique case (cmdCode)
        `CMD_FAULT_LIMIT: begin
          rNxt.rdData = allSel ? {r.faultW[0][`EXP_MSB:`EXP_LSB] + 5'd1,
                        r.faultW[0][`MAN_MSB:0]} : r.faultW[phIdx];
        end
        `CMD_WARN_LIMIT: begin
          rNxt.rdData = allSel ? {r.warnW[0][`EXP_MSB:`EXP_LSB] + 5'd1,
                        r.warnW[0][`MAN_MSB:0]} : r.warnW[phIdx];
        end
        `CMD_FAULT_ACTION: begin
          rNxt.rdData = {8'h00, r.resp};
        end
        default: begin
          rNxt.rdData = 16'h0000;
        end
      endcase
    end
    if (nvmEvent) begin
      for (int i = 0; i < `PHASES; i++) begin
        rNxt.faultW[i] = nvmWord(rNxt.faultW[i]);
        rNxt.warnW[i] = nvmWord(rNxt.warnW[i]);
      end
    end
    for (int i = 0; i < `PHASES; i++) begin
      rNxt.hwF[i] = hwAmps(rNxt.faultW[i]);
      rNxt.hwW[i] = hwAmps(rNxt.warnW[i]);
    end
    // status: clear first so a same-cycle event still sets
    if (clearStatus) begin
      rNxt.stByte = 8'h00;
      rNxt.stWord = 16'h0000;
      rNxt.stIout = 8'h00;
      rNxt.warnSeen = '0;
    end
    if (wrBad) begin
      rNxt.stByte[`SB_CML] = 1'b1;
    end
    if (faultEdge) begin
      rNxt.stByte[`SB_IOUT_OC] = 1'b1;
      rNxt.stWord[`SW_IOUT] = 1'b1;
      rNxt.stIout[`SI_OCF] = 1'b1;
    end
    if (|warnEdge) begin
      rNxt.stByte[`SB_NOTA] = 1'b1;
      rNxt.stWord[`SW_IOUT] = 1'b1;
      rNxt.stIout[`SI_OCW] = 1'b1;
    end
    rNxt.warnSeen = rNxt.warnSeen | warnEdge;
    // fault action and hiccup
    unique case (r.st)
      ST_RUN: begin
        rNxt.tries = 3'd0;
        if (faultEdge && opOn && r.resp[7]) begin
          if (r.resp[6]) begin
            rNxt.st = (r.resp[5:3] == 3'd0) ? ST_LATCH : ST_HICCUP;
            rNxt.hicCnt = 3'd0;
          end else begin
            rNxt.st = ST_DELAY;
            rNxt.dlyCnt = 3'd0;
          end
        end
      end
      ST_DELAY: begin
        if (pwmTick) begin
          rNxt.dlyCnt = r.dlyCnt + 3'd1;
          if (r.dlyCnt + 3'd1 == dlyTicks(r.resp[2:0])) begin
            rNxt.st = (r.resp[5:3] == 3'd0) ? ST_LATCH : ST_HICCUP;
            rNxt.hicCnt = 3'd0;
          end
        end
      end
      ST_HICCUP: begin
        if (riseTick) begin
          rNxt.hicCnt = r.hicCnt + 3'd1;
          if (r.hicCnt + 3'd1 == hicMult(r.resp[2:0])) begin
            rNxt.st = ST_RESTART;
            if (r.resp[5:3] != `RETRY_FOREVER) begin
              rNxt.tries = r.tries + 3'd1;
            end
          end
        end
      end
      ST_RESTART: begin
        if (faultEdge) begin
          rNxt.hicCnt = 3'd0;
          // count 7 never advances tries, so it retries without end
          rNxt.st = (r.resp[5:3] == `RETRY_FOREVER || r.tries < r.resp[5:3]) ?
                    ST_HICCUP : ST_LATCH;
        end else if (startupOk) begin
          rNxt.st = ST_RUN;
        end
      end
      ST_LATCH: begin
      end
      default: begin
        rNxt.st = ST_RUN;
      end
    endcase
    // commanded off ends any shutdown sequence and releases a latch
    if (!opOn) begin
      rNxt.st = ST_RUN;
      rNxt.tries = 3'd0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.resp <= `ACTION_RST;
      for (int i = 0; i < `PHASES; i++) begin
        r.faultW[i] <= `FAULT_W_RST;
        r.warnW[i] <= `WARN_W_RST;
        r.hwF[i] <= `HW_MAX_A;
        r.hwW[i] <= `HW_WARN_RST;
      end
      r.st <= ST_RUN;
    end else if (ce) begin
      r <= rNxt;
    end
  end

  // ==========================================
  // outputs
  assign rdData = r.rdData;
  assign hwFaultAmps = r.hwF;
  assign hwWarnAmps = r.hwW;
  assign statusByte = r.stByte;
  assign statusWord = r.stWord;
  assign statusIout = r.stIout;
  assign warnPhase = r.warnSeen;
  // alert stays up while any status bit is held
  assign alert = |{r.stByte, r.stWord, r.stIout};
  assign convOn = opOn && (r.st == ST_RUN || r.st == ST_DELAY || r.st == ST_RESTART);

  // ==========================================
  // checks
  a_hw_range: assert property (@(posedge mclk) disable iff (sys_rst)
    r.hwF[0] >= `HW_MIN_A && r.hwF[0] <= `HW_MAX_A && !r.hwF[0][0])
    else $error("hardware fault limit outside 8..62 A even");
  a_low_floor: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cmdValid && cmdWrite && cmdCode == `CMD_FAULT_LIMIT && cmdPhase == 8'h01
    && wrData == 16'hF00C && !nvmEvent |=> r.hwF[1] == `HW_MIN_A)
    else $error("small limit not applied as 8 A");
  a_round_up: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cmdValid && cmdWrite && cmdCode == `CMD_FAULT_LIMIT && cmdPhase == 8'h00
    && wrData == 16'hF051 && !nvmEvent |=> r.hwF[0] == 6'd22)
    else $error("limit not rounded to next higher step");
  a_nvm_quant: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && nvmEvent |=> r.faultW[0][`EXP_MSB:`EXP_LSB] == `EXP_RST
    && r.warnW[1][`EXP_MSB:`EXP_LSB] == `EXP_RST)
    else $error("store or restore left limit unquantised");
  a_all_read: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cmdValid && !cmdWrite && cmdCode == `CMD_FAULT_LIMIT && allSel
    |=> r.rdData[`EXP_MSB:`EXP_LSB] == $past(r.faultW[0][`EXP_MSB:`EXP_LSB]) + 5'd1)
    else $error("all-phase read not scaled by phase count");
  a_fault_status: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && faultEdge |=> r.stIout[`SI_OCF] && r.stByte[`SB_IOUT_OC] && alert)
    else $error("fault did not set status and alert");
  a_warn_status: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && |warnEdge |=> r.stByte[`SB_NOTA] && r.stIout[`SI_OCW] && r.stWord[`SW_IOUT])
    else $error("warning did not set status");
  a_ignore_act: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && opOn && r.st == ST_RUN && !r.resp[7] |=> r.st == ST_RUN)
    else $error("ignore action left the run state");
  a_latch_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && opOn && r.st == ST_RUN && faultEdge && r.resp[7:6] == 2'b11
    && r.resp[5:3] == 3'd0 |=> r.st == ST_LATCH ##1 (!convOn || !opOn))
    else $error("zero restart count did not stay off");
  a_bad_write: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && wrBad |=> r.stByte[`SB_CML] && alert)
    else $error("invalid write not flagged");
endmodule

// ===== tb/host_model.sv
// command-port host model that issues limit and action commands
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdPhase,
  output logic [15:0] wrData,
  input wire logic [15:0] rdData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdPhase = 8'h00;
    wrData = 16'h0000;
  end
  // ==========================================
  // one strobe per command; idle lines show the inverse so stale data never matches
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode <= c;
    cmdPhase <= p;
    wrData <= d;
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmdCode <= ~c;
    cmdPhase <= ~p;
    wrData <= ~d;
    #1;
    q = rdData;
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the overcurrent limit and response block
`timescale 1ns/1ps
`include "oc_params.svh"
module tb_top;
  import oc_pkg::*;
  logic mclk, sysRst, ce, cmdValid, cmdWrite, nvmEvent, clearStatus;
  logic pwmTick, riseTick, opOn, startupOk, alert, convOn;
  logic [7:0] cmdCode, cmdPhase, statusByte, statusIout;
  logic [15:0] wrData, rdData, statusWord, q;
  logic [1:0] ocFaultPin, ocWarnPin, warnPhase;
  logic [1:0][5:0] hwFaultAmps, hwWarnAmps;
  int badCount = 0;
  int checks = 0;
  host_model u_host (.mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdPhase(cmdPhase), .wrData(wrData), .rdData(rdData));
  overcurrent_limit_response uut (.mclk(mclk), .sys_rst(sysRst), .ce(ce),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPhase(cmdPhase),
    .wrData(wrData), .rdData(rdData), .nvmEvent(nvmEvent), .clearStatus(clearStatus),
    .ocFaultPin(ocFaultPin), .ocWarnPin(ocWarnPin), .pwmTick(pwmTick),
    .riseTick(riseTick), .opOn(opOn), .startupOk(startupOk),
    .hwFaultAmps(hwFaultAmps), .hwWarnAmps(hwWarnAmps), .statusByte(statusByte),
    .statusWord(statusWord), .statusIout(statusIout), .warnPhase(warnPhase),
    .alert(alert), .convOn(convOn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d);
    u_host.xfer(1'b1, c, p, d, q);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    u_host.xfer(1'b0, c, p, 16'h0000, q);
    chk("rdData", e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic ticks(input logic hic, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (hic) riseTick <= 1'b1;
      else pwmTick <= 1'b1;
      @(posedge mclk);
      riseTick <= 1'b0;
      pwmTick <= 1'b0;
    end
    #1;
  endtask
  // pin change needs two sync stages plus the edge detect
  task automatic pin(input logic fault, input int ph, input logic v);
    @(posedge mclk);
    if (fault) ocFaultPin[ph] <= v;
    else ocWarnPin[ph] <= v;
    cyc(5);
  endtask
  task automatic clr();
    @(posedge mclk);
    clearStatus <= 1'b1;
    @(posedge mclk);
    clearStatus <= 1'b0;
    #1;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {sysRst, ce, nvmEvent, clearStatus, pwmTick, riseTick, startupOk} = 7'b1100000;
    opOn = 1'b1;
    ocFaultPin = 2'b00;
    ocWarnPin = 2'b00;
    repeat (6) @(posedge mclk);
    sysRst <= 1'b0;
    cyc(1);
    chk("hwF1 rst", 16'd62, {10'h0, hwFaultAmps[1]});
    rd(`CMD_FAULT_ACTION, 8'h00, 16'h00C0);
    rd(`CMD_WARN_LIMIT, 8'h00, 16'hF0A0);
    wr(`CMD_FAULT_LIMIT, 8'h00, 16'hF051);
    chk("hwF0 20.25A", 16'd22, {10'h0, hwFaultAmps[0]});
    chk("hwF1 kept", 16'd62, {10'h0, hwFaultAmps[1]});
    rd(`CMD_FAULT_LIMIT, 8'h00, 16'hF051);
    wr(`CMD_FAULT_LIMIT, 8'h01, 16'hF00C);
    chk("hwF1 3A", 16'd8, {10'h0, hwFaultAmps[1]});
    rd(`CMD_FAULT_LIMIT, 8'h01, 16'hF00C);
    wr(`CMD_FAULT_LIMIT, `PHASE_ALL, 16'hF0A0);
    chk("hwF0 all", 16'd20, {10'h0, hwFaultAmps[0]});
    chk("hwF1 all", 16'd20, {10'h0, hwFaultAmps[1]});
    rd(`CMD_FAULT_LIMIT, 8'h00, 16'hE8A0);
    rd(`CMD_FAULT_LIMIT, `PHASE_ALL, 16'hF0A0);
    // a write while the enable is low must leave the stored limit untouched
    @(posedge mclk);
    ce <= 1'b0;
    wr(`CMD_FAULT_LIMIT, 8'h00, 16'hF010);
    @(posedge mclk);
    ce <= 1'b1;
    rd(`CMD_FAULT_LIMIT, 8'h00, 16'hE8A0);
    wr(`CMD_FAULT_LIMIT, 8'h00, 16'hE143);
    @(posedge mclk);
    nvmEvent <= 1'b1;
    @(posedge mclk);
    nvmEvent <= 1'b0;
    rd(`CMD_FAULT_LIMIT, 8'h00, 16'hF051);
    rd(`CMD_FAULT_LIMIT, 8'h01, 16'hF050);
    chk("status clean", 16'h0000, {8'h00, statusByte});
    wr(`CMD_FAULT_LIMIT, 8'h02, 16'hF040);
    chk("bad phase", 16'h0003, {14'h0, statusByte[`SB_CML], alert});
    clr();
    wr(`CMD_WARN_LIMIT, 8'h00, 16'hF400);
    chk("negative", 16'h0003, {14'h0, statusByte[`SB_CML], alert});
    wr(`CMD_WARN_LIMIT, 8'h01, 16'hF0FC);
    chk("warn 63A", 16'd40, {10'h0, hwWarnAmps[1]});
    clr();
    wr(`CMD_WARN_LIMIT, `PHASE_ALL, 16'hF0F8);
    chk("warn 31A", 16'd32, {10'h0, hwWarnAmps[0]});
    chk("no error", 16'h0000, {15'h0, alert});
    pin(1'b0, 1, 1'b1);
    chk("warn phase", 16'h0002, {14'h0, warnPhase});
    chk("warn bits", 16'h001D, {11'h0, statusByte[`SB_NOTA], statusWord[`SW_IOUT],
      statusIout[`SI_OCW], statusByte[`SB_IOUT_OC], alert});
    pin(1'b0, 1, 1'b0);
    clr();
    // reset action: immediate shutdown with no restart
    pin(1'b1, 0, 1'b1);
    ticks(1'b1, 2);
    chk("latch zero", 16'h0000, {15'h0, convOn});
    pin(1'b1, 0, 1'b0);
    @(posedge mclk);
    opOn <= 1'b0;
    @(posedge mclk);
    opOn <= 1'b1;
    clr();
    wr(`CMD_FAULT_ACTION, 8'h00, 16'h00C9);
    pin(1'b1, 0, 1'b1);
    chk("fault bits", 16'h001E, {11'h0, statusByte[`SB_IOUT_OC], statusWord[`SW_IOUT],
      statusIout[`SI_OCF], alert, convOn});
    pin(1'b1, 0, 1'b0);
    ticks(1'b1, 1);
    chk("restart", 16'h0001, {15'h0, convOn});
    pin(1'b1, 0, 1'b1);
    ticks(1'b1, 2);
    chk("latched", 16'h0000, {15'h0, convOn});
    pin(1'b1, 0, 1'b0);
    @(posedge mclk);
    opOn <= 1'b0;
    @(posedge mclk);
    opOn <= 1'b1;
    wr(`CMD_FAULT_ACTION, 8'h00, 16'h00FD);
    repeat (2) begin
      pin(1'b1, 0, 1'b1);
      pin(1'b1, 0, 1'b0);
      ticks(1'b1, 4);
      chk("hiccup 5", 16'h0000, {15'h0, convOn});
      ticks(1'b1, 1);
      chk("retry", 16'h0001, {15'h0, convOn});
    end
    @(posedge mclk);
    startupOk <= 1'b1;
    @(posedge mclk);
    startupOk <= 1'b0;
    wr(`CMD_FAULT_ACTION, 8'h00, 16'h0082);
    pin(1'b1, 0, 1'b1);
    ticks(1'b0, 2);
    chk("delay run", 16'h0001, {15'h0, convOn});
    ticks(1'b0, 1);
    chk("delay off", 16'h0000, {15'h0, convOn});
    pin(1'b1, 0, 1'b0);
    ticks(1'b1, 3);
    chk("no retry", 16'h0000, {15'h0, convOn});
    @(posedge mclk);
    opOn <= 1'b0;
    @(posedge mclk);
    opOn <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      wr(`CMD_FAULT_ACTION, 8'h00, {8'h00, 2'(a), 6'h3F});
      pin(1'b1, 0, 1'b1);
      ticks(1'b0, 8);
      chk("ignore", 16'h0001, {15'h0, convOn});
      pin(1'b1, 0, 1'b0);
    end
    end_of_test();
  end
  initial begin
    #200000;
    badCount++;
    $display("CHECK FAILED run time expected done seen hang");
    end_of_test();
  end
endmodule
